// *** wwdt_pkg.sv ***
// constants, field layouts and types shared by the watchdog files
package wwdt_pkg;

    // ------------------------------------------------------------
    // clock and reset pulse timing
    // ------------------------------------------------------------
    localparam int unsigned WWDT_CLK_MHZ          = 200;
    localparam int unsigned WWDT_RESET_PULSE_US   = 30;
    localparam int unsigned WWDT_RESET_PULSE_CYC  = WWDT_RESET_PULSE_US * WWDT_CLK_MHZ;

    // ------------------------------------------------------------
    // prescaler: 64-period ticks, 256 ticks per full step
    // ------------------------------------------------------------
    localparam int unsigned WWDT_FINE_W           = 6;
    localparam int unsigned WWDT_COARSE_W         = 8;
    localparam int unsigned WWDT_CONST_W          = 6;
    localparam logic [7:0]  WWDT_COARSE_FULL_LAST = 8'hFF;
    localparam logic [7:0]  WWDT_SHORT_BASE       = 8'hC0;
    localparam logic [7:0]  WWDT_COARSE_ONE       = 8'h01;
    localparam logic [5:0]  WWDT_FINE_ONE         = 6'h01;
    localparam logic [5:0]  WWDT_ACC_INC          = 6'h04;

    // ------------------------------------------------------------
    // timebase constants, high and low, per timebase_select code
    // ------------------------------------------------------------
    localparam logic [1:0]  WWDT_TB_00            = 2'h0;
    localparam logic [1:0]  WWDT_TB_01            = 2'h1;
    localparam logic [1:0]  WWDT_TB_10            = 2'h2;
    localparam logic [1:0]  WWDT_TB_11            = 2'h3;
    localparam logic [5:0]  WWDT_HI_00            = 6'h04;
    localparam logic [5:0]  WWDT_LO_00            = 6'h3B;
    localparam logic [5:0]  WWDT_HI_01            = 6'h08;
    localparam logic [5:0]  WWDT_LO_01            = 6'h35;
    localparam logic [5:0]  WWDT_HI_10            = 6'h14;
    localparam logic [5:0]  WWDT_LO_10            = 6'h23;
    localparam logic [5:0]  WWDT_HI_11            = 6'h31;
    localparam logic [5:0]  WWDT_LO_11            = 6'h36;

    // ------------------------------------------------------------
    // watchdog_control_register layout
    // ------------------------------------------------------------
    localparam int unsigned WWDT_CNT_W            = 7;
    localparam logic [7:0]  WWDT_CTRL_RESET       = 8'h7F;
    localparam logic [6:0]  WWDT_CNT_ROLL_FROM    = 7'h40;
    localparam logic [6:0]  WWDT_CNT_ONE          = 7'h01;

    typedef struct packed {
        logic       watchdog_activate_bit;
        logic       counter_top_bit;
        logic [5:0] timeout_step_count;
    } wwdt_ctrl_t;

    typedef struct packed {
        logic [1:0] timebase_select;
        logic       halt_reset_option;
        logic       hw_watchdog;
    } wwdt_cfg_t;

    typedef enum logic [1:0] {
        WWDT_RUN     = 2'b00,
        WWDT_FIRE    = 2'b01,
        WWDT_RECOVER = 2'b11
    } wwdt_state_t;

    typedef enum logic [1:0] {
        WWDT_CAUSE_NONE    = 2'h0,
        WWDT_CAUSE_TIMEOUT = 2'h1,
        WWDT_CAUSE_SOFT    = 2'h2,
        WWDT_CAUSE_HALT    = 2'h3
    } wwdt_cause_t;

endpackage

// *** wwdt_prescaler.sv ***
// free-running prescaler that produces one counter step per timeout step
`timescale 1ns/1ps
module wwdt_prescaler (
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       ce_i,
    input  wire logic [5:0] hi_const_i,
    input  wire logic [5:0] lo_const_i,
    output logic            step_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [5:0] fine_q;
    logic [5:0] fine_d;
    logic [7:0] coarse_q;
    logic [7:0] coarse_d;
    logic [5:0] acc_q;
    logic [5:0] acc_d;
    logic       short_q;
    logic       short_d;
    logic [7:0] last;
    logic [6:0] acc_sum;
    logic       tick;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    // a short step of (192 + low) ticks is spent every high/4 steps
    always_comb begin
        fine_d   = fine_q;
        coarse_d = coarse_q;
        acc_d    = acc_q;
        short_d  = short_q;
        last     = short_q ? 8'(wwdt_pkg::WWDT_SHORT_BASE + {2'h0, lo_const_i}
                               - wwdt_pkg::WWDT_COARSE_ONE)
                           : wwdt_pkg::WWDT_COARSE_FULL_LAST;
        tick     = &fine_q;
        step_o   = ce_i && tick && (coarse_q >= last);
        acc_sum  = {1'b0, acc_q} + {1'b0, wwdt_pkg::WWDT_ACC_INC};
        if (ce_i) begin
            fine_d = fine_q + wwdt_pkg::WWDT_FINE_ONE;
            if (step_o) begin
                coarse_d = '0;
                if (acc_sum >= {1'b0, hi_const_i}) begin
                    acc_d   = 6'(acc_sum - {1'b0, hi_const_i});
                    short_d = 1'b1;
                end else begin
                    acc_d   = acc_sum[5:0];
                    short_d = 1'b0;
                end
            end else if (tick) begin
                coarse_d = coarse_q + wwdt_pkg::WWDT_COARSE_ONE;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // never cleared by a control write, so the first step lands anywhere
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            fine_q   <= '0;
            coarse_q <= '0;
            acc_q    <= '0;
            short_q  <= 1'b0;
        end else begin
            fine_q   <= fine_d;
            coarse_q <= coarse_d;
            acc_q    <= acc_d;
            short_q  <= short_d;
        end
    end

endmodule

// *** wwdt_pulse.sv ***
// stretcher that holds the reset line low for a fixed number of cycles
`timescale 1ns/1ps
module wwdt_pulse #(
    parameter int unsigned CYCLES = wwdt_pkg::WWDT_RESET_PULSE_CYC
) (
    input  wire logic mclk_i,
    input  wire logic rst_n_i,
    input  wire logic ce_i,
    input  wire logic start_i,
    output logic      busy_o,
    output logic      done_o
);

    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE  = CW'(1);

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic          busy_q;
    logic          busy_d;

    always_comb begin
        cnt_d  = cnt_q;
        busy_d = busy_q;
        done_o = ce_i && busy_q && (cnt_q == ONE);
        if (ce_i) begin
            if (start_i && !busy_q) begin
                cnt_d  = LOAD;
                busy_d = 1'b1;
            end else if (busy_q) begin
                cnt_d = cnt_q - ONE;
                if (cnt_q == ONE) begin
                    busy_d = 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q  <= '0;
            busy_q <= 1'b0;
        end else begin
            cnt_q  <= cnt_d;
            busy_q <= busy_d;
        end
    end

    assign busy_o = busy_q;

endmodule

// *** wwdt_top.sv ***
// windowed watchdog timer: control register, counter and reset generation
//
// What this block does
// - counter steps once per about 16384 oscillator periods via prescaler
// - timeout is programmable in 64 steps by the low six counter bits
// - active and counter goes 40h to 3Fh: reset line low about 30us
// - counter runs even while inactive; only the reset is gated
// - inactive after reset; once active, no write can deactivate it
// - write with activation set and top bit clear forces a reset
// - halt executed while active, with the halt option set, resets the chip instead of halting
// - control writes never resynchronise the prescaler
// - timebase select picks the high and low timing constants
// - minimum timeout built from low constant and periodic short steps
// - option selects whether halt while active produces a reset
// - option gives hardware watchdog mode, active without software
// - register: activation bit 7, counter bits 6..0, resets to 7Fh
// - maximum timeout base 16384 periods, same per-step accumulation
`timescale 1ns/1ps
module wwdt_top #(
    parameter int unsigned RESET_PULSE_CYCLES = wwdt_pkg::WWDT_RESET_PULSE_CYC
) (
    input  wire logic                mclk_i,
    input  wire logic                rst_n_i,
    input  wire logic                ce_i,
    input  wwdt_pkg::wwdt_cfg_t      cfg_i,
    input  wire logic                wr_en_i,
    input  wwdt_pkg::wwdt_ctrl_t     wr_data_i,
    input  wire logic                halt_exec_i,
    output wwdt_pkg::wwdt_ctrl_t     rd_data_o,
    output logic                     active_o,
    output logic                     halt_grant_o,
    output logic                     wdg_reset_n_o,
    output wwdt_pkg::wwdt_cause_t    reset_cause_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    wwdt_pkg::wwdt_state_t state_q;
    wwdt_pkg::wwdt_state_t state_d;
    wwdt_pkg::wwdt_cause_t cause_q;
    wwdt_pkg::wwdt_cause_t cause_d;
    logic                  act_q;
    logic                  act_d;
    logic [6:0]            cnt_q;
    logic [6:0]            cnt_d;
    logic                  fire_q;
    logic                  fire_d;
    logic [5:0]            hi_const;
    logic [5:0]            lo_const;
    logic                  step;
    logic                  act_eff;
    logic                  act_next;
    logic [6:0]            wr_cnt;
    logic                  soft_fire;
    logic                  time_fire;
    logic                  halt_fire;
    logic                  start;
    logic                  pulse_busy;
    logic                  pulse_done;
    logic                  rst_line_q;
    logic                  rst_line_d;

    // ------------------------------------------------------------
    // timebase constants
    // ------------------------------------------------------------
    always_comb begin
        hi_const = wwdt_pkg::WWDT_HI_00;
        lo_const = wwdt_pkg::WWDT_LO_00;
        unique case (cfg_i.timebase_select)
            wwdt_pkg::WWDT_TB_00: begin
                hi_const = wwdt_pkg::WWDT_HI_00;
                lo_const = wwdt_pkg::WWDT_LO_00;
            end
            wwdt_pkg::WWDT_TB_01: begin
                hi_const = wwdt_pkg::WWDT_HI_01;
                lo_const = wwdt_pkg::WWDT_LO_01;
            end
            wwdt_pkg::WWDT_TB_10: begin
                hi_const = wwdt_pkg::WWDT_HI_10;
                lo_const = wwdt_pkg::WWDT_LO_10;
            end
            wwdt_pkg::WWDT_TB_11: begin
                hi_const = wwdt_pkg::WWDT_HI_11;
                lo_const = wwdt_pkg::WWDT_LO_11;
            end
        endcase
    end

    // ------------------------------------------------------------
    // prescaler and reset stretcher
    // ------------------------------------------------------------
    wwdt_prescaler u_presc (
        .mclk_i     (mclk_i),
        .rst_n_i    (rst_n_i),
        .ce_i       (ce_i),
        .hi_const_i (hi_const),
        .lo_const_i (lo_const),
        .step_o     (step)
    );

    wwdt_pulse #(
        .CYCLES (RESET_PULSE_CYCLES)
    ) u_pulse (
        .mclk_i  (mclk_i),
        .rst_n_i (rst_n_i),
        .ce_i    (ce_i),
        .start_i (start),
        .busy_o  (pulse_busy),
        .done_o  (pulse_done)
    );

    // ------------------------------------------------------------
    // trigger conditions
    // ------------------------------------------------------------
    // the hardware option is a live strap, so it also covers a write
    // that lands while the activation bit is still clear
    assign act_eff  = act_q | cfg_i.hw_watchdog;
    assign wr_cnt   = {wr_data_i.counter_top_bit, wr_data_i.timeout_step_count};
    assign act_next = act_eff | wr_data_i.watchdog_activate_bit;

    always_comb begin
        soft_fire = 1'b0;
        time_fire = 1'b0;
        halt_fire = 1'b0;
        if (ce_i && (state_q == wwdt_pkg::WWDT_RUN)) begin
            soft_fire = wr_en_i && act_next && !wr_data_i.counter_top_bit;
            time_fire = !wr_en_i && step && act_eff
                        && (cnt_q == wwdt_pkg::WWDT_CNT_ROLL_FROM);
            halt_fire = halt_exec_i && act_eff && cfg_i.halt_reset_option;
        end
    end

    // halt is granted only when it does not turn into a reset
    assign halt_grant_o = ce_i && halt_exec_i && (state_q == wwdt_pkg::WWDT_RUN)
                          && !halt_fire;
    assign start        = fire_q;

    // ------------------------------------------------------------
    // control register and sequence, next state
    // ------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        cause_d    = cause_q;
        act_d      = act_q;
        cnt_d      = cnt_q;
        // hold the start request while frozen, or the pulse never starts
        fire_d     = fire_q;
        rst_line_d = rst_line_q;
        if (ce_i) begin
            fire_d = 1'b0;
            unique case (state_q)
                wwdt_pkg::WWDT_RUN: begin
                    if (wr_en_i) begin
                        act_d = act_q | wr_data_i.watchdog_activate_bit;
                        cnt_d = wr_cnt;
                    end else if (step) begin
                        cnt_d = cnt_q - wwdt_pkg::WWDT_CNT_ONE;
                    end
                    if (halt_fire || soft_fire || time_fire) begin
                        state_d    = wwdt_pkg::WWDT_FIRE;
                        fire_d     = 1'b1;
                        rst_line_d = 1'b1;
                        if (halt_fire) begin
                            cause_d = wwdt_pkg::WWDT_CAUSE_HALT;
                        end else if (soft_fire) begin
                            cause_d = wwdt_pkg::WWDT_CAUSE_SOFT;
                        end else begin
                            cause_d = wwdt_pkg::WWDT_CAUSE_TIMEOUT;
                        end
                    end
                end
                wwdt_pkg::WWDT_FIRE: begin
                    // writes and halts are ignored while the line is held
                    if (pulse_done) begin
                        rst_line_d = 1'b0;
                        state_d    = wwdt_pkg::WWDT_RECOVER;
                    end
                end
                wwdt_pkg::WWDT_RECOVER: begin
                    // the chip has been reset: back to the reset value
                    act_d   = wwdt_pkg::WWDT_CTRL_RESET[7];
                    cnt_d   = wwdt_pkg::WWDT_CTRL_RESET[6:0];
                    state_d = wwdt_pkg::WWDT_RUN;
                end
                default: begin
                    state_d = wwdt_pkg::WWDT_RUN;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q    <= wwdt_pkg::WWDT_RUN;
            cause_q    <= wwdt_pkg::WWDT_CAUSE_NONE;
            act_q      <= wwdt_pkg::WWDT_CTRL_RESET[7];
            cnt_q      <= wwdt_pkg::WWDT_CTRL_RESET[6:0];
            fire_q     <= 1'b0;
            rst_line_q <= 1'b0;
        end else begin
            state_q    <= state_d;
            cause_q    <= cause_d;
            act_q      <= act_d;
            cnt_q      <= cnt_d;
            fire_q     <= fire_d;
            rst_line_q <= rst_line_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // the read value shows the stored bit, not the hardware option
    assign rd_data_o                       = {act_q, cnt_q};
    assign active_o                        = act_eff;
    assign wdg_reset_n_o                   = !(rst_line_q | pulse_busy);
    assign reset_cause_o                   = cause_q;

endmodule

// *** wwdt_top_assertions.sv ***
// concurrent checks on the watchdog top module ports
`timescale 1ns/1ps
module wwdt_top_assertions #(
    parameter int unsigned RESET_PULSE_CYCLES = wwdt_pkg::WWDT_RESET_PULSE_CYC
) (
    input  wire logic            mclk_i,
    input  wire logic            rst_n_i,
    input  wire logic            ce_i,
    input  wwdt_pkg::wwdt_cfg_t  cfg_i,
    input  wire logic            wr_en_i,
    input  wwdt_pkg::wwdt_ctrl_t wr_data_i,
    input  wire logic            halt_exec_i,
    input  wwdt_pkg::wwdt_ctrl_t rd_data_o,
    input  wire logic            active_o,
    input  wire logic            halt_grant_o,
    input  wire logic            wdg_reset_n_o,
    input  wwdt_pkg::wwdt_cause_t reset_cause_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // low-time counter: pulse is far longer than a repetition may be
    // ------------------------------------------------------------
    logic [15:0] low_cnt_d;
    logic [15:0] low_cnt_q;

    always_comb begin
        // a frozen cycle stretches the pulse, so it is not counted
        low_cnt_d = wdg_reset_n_o ? 16'h0000 : (ce_i ? low_cnt_q + 16'h0001 : low_cnt_q);
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            low_cnt_q <= 16'h0000;
        end else begin
            low_cnt_q <= low_cnt_d;
        end
    end

    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    write_load_a: assert property (wr_en_i && ce_i && !halt_exec_i && wdg_reset_n_o
        && $past(wdg_reset_n_o) |=> rd_data_o[6:0] == $past(wr_data_i[6:0]))
        else $error("written count not loaded");
    act_sticky_a: assert property ($fell(rd_data_o.watchdog_activate_bit)
        |-> !$past(wdg_reset_n_o, 2) || !$past(wdg_reset_n_o, 3))
        else $error("activation cleared without a reset");
    soft_reset_a: assert property (wr_en_i && ce_i && wdg_reset_n_o && $past(wdg_reset_n_o)
        && (active_o || wr_data_i.watchdog_activate_bit) && !wr_data_i.counter_top_bit
        |=> !wdg_reset_n_o) else $error("software reset not produced");
    halt_reset_a: assert property (halt_exec_i && ce_i && active_o && cfg_i.halt_reset_option
        && wdg_reset_n_o && $past(wdg_reset_n_o)
        |=> !wdg_reset_n_o && reset_cause_o == wwdt_pkg::WWDT_CAUSE_HALT)
        else $error("halt while active did not reset");
    halt_grant_a: assert property (halt_exec_i && ce_i && wdg_reset_n_o && $past(wdg_reset_n_o)
        && !(active_o && cfg_i.halt_reset_option) |-> halt_grant_o)
        else $error("plain halt not granted");
    hw_active_a: assert property (cfg_i.hw_watchdog |-> active_o)
        else $error("hardware mode not active");
    pulse_len_a: assert property ($rose(wdg_reset_n_o)
        |-> low_cnt_q == 16'(RESET_PULSE_CYCLES + 1))
        else $error("reset pulse length wrong");
    cause_sticky_a: assert property ($changed(reset_cause_o) |-> $fell(wdg_reset_n_o))
        else $error("cause changed outside a reset");
    timeout_a: assert property ($fell(rd_data_o.counter_top_bit) && !$past(wr_en_i)
        && $past(active_o) && $past(wdg_reset_n_o) |-> !wdg_reset_n_o)
        else $error("top bit cleared while active without reset");
endmodule

bind wwdt_top wwdt_top_assertions #(
    .RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)
) wwdt_top_assertions_inst (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg_i(cfg_i),
    .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .halt_exec_i(halt_exec_i),
    .rd_data_o(rd_data_o), .active_o(active_o), .halt_grant_o(halt_grant_o),
    .wdg_reset_n_o(wdg_reset_n_o), .reset_cause_o(reset_cause_o)
);

// *** wwdt_top_bench.sv ***
// self-checking testbench for the watchdog top module
`timescale 1ns/1ps
module wwdt_top_bench;
    // short pulse keeps the run small; expectations derive from it
    localparam int unsigned PULSE = 20;
    // second step is short with timebase 00: (192 + 59) ticks of 64 periods
    localparam int unsigned SHORT_STEP = (192 + 59) * 64;

    logic                  mclk_i;
    logic                  rst_n_i;
    logic                  ce_i;
    wwdt_pkg::wwdt_cfg_t   cfg_i;
    logic                  wr_en_i;
    wwdt_pkg::wwdt_ctrl_t  wr_data_i;
    logic                  halt_exec_i;
    wwdt_pkg::wwdt_ctrl_t  rd_data_o;
    logic                  active_o;
    logic                  halt_grant_o;
    logic                  wdg_reset_n_o;
    wwdt_pkg::wwdt_cause_t reset_cause_o;
    int                    errors;
    int                    checks;
    int                    n;

    wwdt_top #(.RESET_PULSE_CYCLES(PULSE)) wwdt_top_inst (
        .mclk_i(mclk_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .cfg_i(cfg_i),
        .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .halt_exec_i(halt_exec_i),
        .rd_data_o(rd_data_o), .active_o(active_o), .halt_grant_o(halt_grant_o),
        .wdg_reset_n_o(wdg_reset_n_o), .reset_cause_o(reset_cause_o)
    );

    initial begin
        mclk_i = 1'b0;
        forever #2.5 mclk_i = ~mclk_i;
    end

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic write_reg(input logic [7:0] v);
        @(posedge mclk_i);
        wr_en_i <= 1'b1;
        wr_data_i <= v;
        @(posedge mclk_i);
        wr_en_i <= 1'b0;
    endtask

    task automatic halt_pulse(input logic exp_grant);
        @(posedge mclk_i);
        halt_exec_i <= 1'b1;
        #1;
        check("halt grant", {7'h00, exp_grant}, {7'h00, halt_grant_o});
        @(posedge mclk_i);
        halt_exec_i <= 1'b0;
    endtask

    // bounded wait for the reset line to drop; cyc reports the cycles spent
    task automatic wait_low(input int lim, output int cyc);
        cyc = 0;
        #1;
        while (wdg_reset_n_o !== 1'b0 && cyc < lim) begin
            @(posedge mclk_i);
            #1;
            cyc++;
        end
    endtask

    task automatic recover;
        int c;
        c = 0;
        while (wdg_reset_n_o !== 1'b1 && c < 100) begin
            @(posedge mclk_i);
            #1;
            c++;
        end
        @(posedge mclk_i);
        #1;
    endtask

    task automatic print_verdict;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // watchdog and tests
    // ------------------------------------------------------------
    initial begin
        repeat (40000) @(posedge mclk_i);
        errors++;
        $display("Error run expected finish seen hang");
        print_verdict();
    end

    initial begin
        errors = 0;
        checks = 0;
        ce_i = 1'b1;
        cfg_i = '0;
        wr_en_i = 1'b0;
        wr_data_i = 8'h00;
        halt_exec_i = 1'b0;
        rst_n_i = 1'b0;
        repeat (12) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        check("rd reset", 8'h7F, rd_data_o);
        check("line reset", 8'h01, {7'h00, wdg_reset_n_o});
        check("cause reset", 8'h00, {6'h00, reset_cause_o});
        check("active reset", 8'h00, {7'h00, active_o});
        n = 0;
        while (rd_data_o === 8'h7F && n < 20000) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check("first step", 8'h01, {7'h00, (n >= 16380 && n <= 16390)});
        check("free count", 8'h7E, rd_data_o);
        $display("test step done");
        // a write mid-step must not restart the prescaler phase
        repeat (8000) @(posedge mclk_i);
        write_reg(8'hC0);
        #1;
        check("refresh", 8'hC0, rd_data_o);
        wait_low(9000, n);
        check("no resync", 8'h01, {7'h00, n < 9000});
        // 8000 idle cycles plus the two write cycles passed since the first step
        check("short step", 8'h01, {7'h00, n == SHORT_STEP - 8002});
        check("cause timeout", 8'h01, {6'h00, reset_cause_o});
        recover();
        check("after fire", 8'h7F, rd_data_o);
        $display("test timeout done");
        write_reg(8'hC5);
        #1;
        check("load", 8'hC5, rd_data_o);
        write_reg(8'h45);
        #1;
        check("sticky act", 8'hC5, rd_data_o);
        halt_pulse(1'b1);
        @(posedge mclk_i);
        cfg_i.halt_reset_option <= 1'b1;
        halt_pulse(1'b0);
        wait_low(4, n);
        check("cause halt", 8'h03, {6'h00, reset_cause_o});
        recover();
        halt_pulse(1'b1);
        $display("test halt done");
        write_reg(8'h80);
        wait_low(4, n);
        check("cause soft", 8'h02, {6'h00, reset_cause_o});
        n = 0;
        while (wdg_reset_n_o === 1'b0 && n < 100) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        check("pulse length", 8'(PULSE + 1), 8'(n));
        recover();
        check("soft cleared", 8'h7F, rd_data_o);
        $display("test soft reset done");
        @(posedge mclk_i);
        cfg_i.hw_watchdog <= 1'b1;
        #1;
        check("hw active", 8'h01, {7'h00, active_o});
        write_reg(8'h3F);
        wait_low(4, n);
        check("hw soft", 8'h02, {6'h00, reset_cause_o});
        recover();
        @(posedge mclk_i);
        ce_i <= 1'b0;
        write_reg(8'hC1);
        #1;
        check("frozen write", 8'h7F, rd_data_o);
        @(posedge mclk_i);
        ce_i <= 1'b1;
        @(posedge mclk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        #1;
        check("cause rerst", 8'h00, {6'h00, reset_cause_o});
        check("rd rerst", 8'h7F, rd_data_o);
        $display("test hardware mode done");
        print_verdict();
    end
endmodule
